// file: logic/rsi_pkg.sv
package rsi_pkg;
  // ==================================================
  // timing
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned T_DATA_MS      = 50;
  localparam int unsigned T_GATE_MS      = 850;
  localparam int unsigned T_SETTLE_MS    = 314;
  localparam int unsigned T_PAUSE_MS     = 72;
  localparam int unsigned T_BIT_MS       = 4;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned MS_CNT_W       = 18;
  localparam logic [MS_CNT_W-1:0] MS_TICK_LAST = MS_CNT_W'(CYC_PER_MS - 1);
  localparam logic [9:0] WAIT_DATA_LAST   = 10'(T_DATA_MS - 1);
  localparam logic [9:0] WAIT_GATE_LAST   = 10'(T_GATE_MS - 1);
  localparam logic [9:0] WAIT_SETTLE_LAST = 10'(T_SETTLE_MS - 1);
  localparam logic [9:0] WAIT_PAUSE_LAST  = 10'(T_PAUSE_MS - 1);
  localparam logic [9:0] WAIT_BIT_LAST    = 10'(T_BIT_MS - 1);
  // ==================================================
  // frame layout: start, 8 data, 2 stop
  localparam logic [3:0] BIT_LAST  = 4'ha;
  localparam logic [1:0] CHAR_LAST = 2'h3;
  localparam logic [7:0] CHR_S = 8'h53;
  localparam logic [7:0] CHR_C = 8'h43;
  localparam logic [7:0] CHR_E = 8'h45;
  localparam logic [7:0] CHR_A = 8'h41;
  localparam logic [7:0] CHR_I = 8'h49;
  // ==================================================
  // types: regions, states, pin set, sequencer state
  typedef enum logic [1:0] {RSI_REG_A, RSI_REG_E, RSI_REG_I} rsi_region_e;
  typedef enum logic [2:0] {
    RSI_ST_RELEASE, RSI_ST_DATA_LOW, RSI_ST_SETTLE, RSI_ST_PAUSE, RSI_ST_SEND, RSI_ST_IDLE
  } rsi_state_e;
  typedef struct packed {
    logic gate_oe;
    logic data_oe;
    logic pri_addr;
    logic sec_addr;
    logic sending;
  } rsi_pins_s;
  typedef struct packed {
    rsi_state_e           st;
    logic [MS_CNT_W-1:0]  tick_cnt;
    logic [9:0]           ms_cnt;
    logic [3:0]           bit_idx;
    logic [1:0]           chr_idx;
    rsi_region_e          cur_reg;
    logic                 lid_prev;
    logic                 rearm;
    logic                 line_one;
    rsi_pins_s            pins;
  } rsi_state_s;
endpackage

// file: logic/rsi_injector.sv
// Overview of operation
// - release, data low 50ms, gate 850ms, wait 314ms
// - every bit held four milliseconds
// - one drives line low, zero releases
// - start zero, eight bits lsb first, two stops
// - endless loop, 72ms pause, four characters
// - data and gate outputs never drive high, enables only
// - gate low option for genuine discs
// - multi-region cycles the three signatures, one per pass
// - stealth sends only after power-up, lid
// - primary address carries inverted characters
// - older boards: secondary carries uninverted characters
// - newer boards: secondary held one while sending
module rsi_injector
  import rsi_pkg::*;
#(
  // last clock of one millisecond; a bench may shrink it to keep runs short
  parameter logic [MS_CNT_W-1:0] TICK_LAST = MS_TICK_LAST
)
(
  input  wire logic        sys_clk_in,        // 200 MHz clock
  input  wire logic        sys_rst_in,        // async reset, active high
  input  wire logic [1:0]  region_sel_in,     // fixed region: 0 A, 1 E, 2 I
  input  wire logic        multi_region_in,   // cycle regions each pass
  input  wire logic        stealth_in,        // send only after power-up or lid open
  input  wire logic        lid_open_sense_in, // high while lid is open
  input  wire logic        newer_board_in,    // selects secondary address behaviour
  input  wire logic        gate_hold_in,      // drive gate low after power-up
  output logic             data_oe_out,       // data pin pulled low when high
  output logic             gate_oe_out,       // gate pin pulled low when high
  output logic             primary_addr_output_out,   // inverted stream
  output logic             secondary_addr_output_out, // uninverted or buffer enable
  output logic             sending_out        // signature pass in progress
);
  rsi_state_s s_r, s_nxt;
  logic [7:0] chr;
  logic       bit_val;

  // ==================================================
  // character and bit selection
  always_comb begin
    chr = CHR_S;
    unique case (s_r.chr_idx)
      2'h0: chr = CHR_S;
      2'h1: chr = CHR_C;
      2'h2: chr = CHR_E;
      default: begin
        unique case (s_r.cur_reg)
          RSI_REG_E: chr = CHR_E;
          RSI_REG_I: chr = CHR_I;
          default:   chr = CHR_A;
        endcase
      end
    endcase
    if (s_r.bit_idx == 4'h0) begin
      bit_val = 1'b0;
    end else if (s_r.bit_idx > 4'h8) begin
      bit_val = 1'b1;
    end else begin
      bit_val = chr[3'(s_r.bit_idx - 4'h1)];
    end
  end

  // ==================================================
  // sequencer
  always_comb begin
    logic ms_tick;
    logic wait_done;
    logic [9:0] lim;
    s_nxt = s_r;
    ms_tick = 1'b0;
    lim = WAIT_BIT_LAST;
    if (s_r.tick_cnt == TICK_LAST) begin
      s_nxt.tick_cnt = '0;
      ms_tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    end
    unique case (s_r.st)
      RSI_ST_RELEASE:  lim = WAIT_DATA_LAST;
      RSI_ST_DATA_LOW: lim = WAIT_GATE_LAST;
      RSI_ST_SETTLE:   lim = WAIT_SETTLE_LAST;
      RSI_ST_PAUSE:    lim = WAIT_PAUSE_LAST;
      default:         lim = WAIT_BIT_LAST;
    endcase
    wait_done = ms_tick && (s_r.ms_cnt == lim);
    if (ms_tick) begin
      s_nxt.ms_cnt = wait_done ? 10'h0 : s_r.ms_cnt + 10'h1;
    end
    s_nxt.lid_prev = lid_open_sense_in;
    unique case (s_r.st)
      RSI_ST_RELEASE: begin
        if (wait_done) begin
          s_nxt.st = RSI_ST_DATA_LOW;
          s_nxt.line_one = 1'b1;
        end
      end
      RSI_ST_DATA_LOW: begin
        if (wait_done) begin
          s_nxt.st = RSI_ST_SETTLE;
          s_nxt.pins.gate_oe = gate_hold_in;
        end
      end
      RSI_ST_SETTLE: begin
        if (wait_done) begin
          s_nxt.st = RSI_ST_PAUSE;
        end
      end
      RSI_ST_PAUSE: begin
        s_nxt.line_one = 1'b1;
        if (wait_done) begin
          s_nxt.st = RSI_ST_SEND;
          s_nxt.bit_idx = '0;
          s_nxt.chr_idx = '0;
          s_nxt.rearm = 1'b0;
        end
      end
      RSI_ST_SEND: begin
        s_nxt.line_one = bit_val;
        if (wait_done) begin
          if (s_r.bit_idx != BIT_LAST) begin
            s_nxt.bit_idx = s_r.bit_idx + 4'h1;
          end else begin
            s_nxt.bit_idx = '0;
            if (s_r.chr_idx != CHAR_LAST) begin
              s_nxt.chr_idx = s_r.chr_idx + 2'h1;
            end else begin
              s_nxt.chr_idx = '0;
              if (multi_region_in) begin
                s_nxt.cur_reg = (s_r.cur_reg == RSI_REG_I) ? RSI_REG_A
                              : rsi_region_e'(s_r.cur_reg + 2'h1);
              end else begin
                s_nxt.cur_reg = rsi_region_e'(region_sel_in);
              end
              s_nxt.st = (stealth_in && !s_nxt.rearm) ? RSI_ST_IDLE : RSI_ST_PAUSE;
            end
          end
        end
      end
      RSI_ST_IDLE: begin
        s_nxt.line_one = 1'b0;
        if (s_r.rearm || !stealth_in) begin
          s_nxt.st = RSI_ST_PAUSE;
          s_nxt.ms_cnt = '0;
        end
      end
      default: s_nxt.st = RSI_ST_IDLE;
    endcase
    // lid opening rearms stealth
    // placed after the pass-start clear so a lid edge in that cycle is not lost
    if (lid_open_sense_in && !s_r.lid_prev) begin
      s_nxt.rearm = 1'b1;
    end
    if (s_nxt.st == RSI_ST_IDLE) begin
      s_nxt.line_one = 1'b0;
    end
    // data pin only enabled, never a high drive; address pins are driven high and low
    s_nxt.pins.data_oe = s_nxt.line_one;
    s_nxt.pins.pri_addr = (s_nxt.st == RSI_ST_SEND) ? !s_nxt.line_one : 1'b1;
    s_nxt.pins.sec_addr = (s_nxt.st != RSI_ST_SEND) ? 1'b0
                        : (newer_board_in ? 1'b1 : s_nxt.line_one);
    // registered so the status output comes straight from a flop
    s_nxt.pins.sending = (s_nxt.st == RSI_ST_SEND);
  end

  // ==================================================
  // state register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_r <= '{st: RSI_ST_RELEASE, cur_reg: RSI_REG_A, pins: '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_oe_out               = s_r.pins.data_oe;
  assign gate_oe_out               = s_r.pins.gate_oe;
  assign primary_addr_output_out   = s_r.pins.pri_addr;
  assign secondary_addr_output_out = s_r.pins.sec_addr;
  assign sending_out               = s_r.pins.sending;

  // ==================================================
  // checks
  AST_BIT_HOLD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    ($changed(s_r.bit_idx) && s_r.st == RSI_ST_SEND) |-> s_r.tick_cnt == '0)
    else $error("bit index moved off a millisecond boundary");
  AST_START_ZERO: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (s_r.st == RSI_ST_SEND && s_r.bit_idx == 4'h0) |=> (!data_oe_out || s_r.bit_idx != 4'h0))
    else $error("start bit drove the line");
  AST_STOP_ONE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (s_r.st == RSI_ST_SEND && s_r.bit_idx > 4'h8 && $stable(s_r.bit_idx)) |-> data_oe_out)
    else $error("stop bit released the line");
  AST_PAUSE_LOW: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (s_r.st == RSI_ST_PAUSE && $past(s_r.st) == RSI_ST_PAUSE) |-> data_oe_out)
    else $error("pause not at one level");
  AST_RELEASE_FIRST: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_r.st == RSI_ST_RELEASE |-> (!data_oe_out && !gate_oe_out))
    else $error("pins driven before data delay");
  AST_PRI_INV: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    sending_out |-> primary_addr_output_out == !data_oe_out)
    else $error("primary address not inverted stream");
  AST_SEC_NEW: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (sending_out && newer_board_in && $stable(newer_board_in)) |-> secondary_addr_output_out)
    else $error("secondary address not held one");
  AST_SEC_OLD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (sending_out && !$past(newer_board_in)) |-> secondary_addr_output_out == data_oe_out)
    else $error("secondary address not uninverted stream");
  AST_STEALTH: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (s_r.st == RSI_ST_IDLE) |-> !data_oe_out)
    else $error("line driven while silent");
  AST_REGION_CYCLE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    ($past(multi_region_in) && $changed(s_r.cur_reg)) |->
      s_r.cur_reg == (($past(s_r.cur_reg) == RSI_REG_A) ? RSI_REG_E
                    : ($past(s_r.cur_reg) == RSI_REG_E) ? RSI_REG_I : RSI_REG_A))
    else $error("region did not advance");
  COV_SEND: cover property (@(posedge sys_clk_in) $rose(sending_out));
  COV_IDLE: cover property (@(posedge sys_clk_in) s_r.st == RSI_ST_IDLE);
  COV_REGION_I: cover property (@(posedge sys_clk_in) s_r.cur_reg == RSI_REG_I);
  COV_REARM: cover property (@(posedge sys_clk_in)
    s_r.st == RSI_ST_IDLE ##1 s_r.st == RSI_ST_PAUSE);
endmodule

// file: verification/rsi_console_model.sv
// ==================================================
// console side: data node, gate node, sync point
module rsi_console_model (
  input  wire logic sys_clk_in,    // bench clock
  input  wire logic data_oe_in,    // injector pulls data low
  input  wire logic gate_oe_in,    // injector pulls gate low
  output logic      data_node_out, // level seen on the data node
  output logic      sync_out       // slow sync clock of the drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        gate_node;
  logic [14:0] div_r = 15'h0;
  logic        sync_r = 1'b0;
  // gate node has a pull-up, so a released gate reads high
  assign gate_node = ~gate_oe_in;
  // sync rewired: no disc signature; the injected stream shows only while the gate is pulled low, else the node reads low
  assign data_node_out = data_oe_in ? 1'b0 : ~gate_node;
  // sync near 7.35 kHz; injector ignores it
  always_ff @(posedge sys_clk_in) begin
    div_r <= (div_r == 15'h3524) ? 15'h0 : div_r + 15'h1;
    if (div_r == 15'h3524) begin
      sync_r <= ~sync_r;
    end
  end
  assign sync_out = sync_r;
endmodule

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsi_pkg::*;
  // one millisecond shrinks to 20 clocks so the whole run stays short
  localparam int MS = 20;
  localparam logic [MS_CNT_W-1:0] TB_TICK_LAST = MS_CNT_W'(MS - 1);
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [1:0] region_sel_in = 2'h0;
  logic multi_region_in = 1'b0;
  logic stealth_in = 1'b0;
  logic lid_open_sense_in = 1'b0;
  logic newer_board_in = 1'b0;
  logic gate_hold_in = 1'b1;
  logic data_oe_out, gate_oe_out, pri_out, sec_out, sending_out, data_node, sync;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  rsi_injector #(.TICK_LAST(TB_TICK_LAST)) i_dut (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .region_sel_in(region_sel_in),
    .multi_region_in(multi_region_in), .stealth_in(stealth_in),
    .lid_open_sense_in(lid_open_sense_in), .newer_board_in(newer_board_in),
    .gate_hold_in(gate_hold_in), .data_oe_out(data_oe_out), .gate_oe_out(gate_oe_out),
    .primary_addr_output_out(pri_out), .secondary_addr_output_out(sec_out),
    .sending_out(sending_out));
  rsi_console_model i_console (.sys_clk_in(sys_clk_in), .data_oe_in(data_oe_out),
    .gate_oe_in(gate_oe_out), .data_node_out(data_node), .sync_out(sync));
  // ==================================================
  // clock and run limit; two power-up sequences and four passes need about 72k clocks
  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 80_000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // count negedges until the chosen output goes high, bounded
  task automatic wait_hi(int sel, int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk_in);
      cnt++;
    end while (cnt < lim && ({sending_out, gate_oe_out, data_oe_out} >> sel) % 2 == 0);
  endtask
  // one signature pass sampled mid-bit; lsb first framing
  // quiet: stealth is on, so the line must be released after the pass
  task automatic chk_pass(logic [7:0] last, logic quiet);
    logic [31:0] word;
    logic bitv;
    word = {last, 8'h45, 8'h43, 8'h53};
    repeat (T_BIT_MS * MS / 2) @(negedge sys_clk_in);
    for (int k = 0; k < 44; k++) begin
      bitv = (k % 11 == 0) ? 1'b0 : (k % 11 > 8) ? 1'b1 : word[(k / 11) * 8 + k % 11 - 1];
      chk("data oe", {7'h0, bitv}, {7'h0, data_oe_out});
      chk("data node", {7'h0, ~bitv & gate_hold_in}, {7'h0, data_node});
      chk("primary addr", {7'h0, ~bitv}, {7'h0, pri_out});
      chk("secondary addr", {7'h0, newer_board_in | bitv}, {7'h0, sec_out});
      chk("sending", 8'h1, {7'h0, sending_out});
      if (k < 43) repeat (T_BIT_MS * MS) @(negedge sys_clk_in);
    end
    repeat (T_BIT_MS * MS / 2 + 10) @(negedge sys_clk_in);
    chk("pause line", {7'h0, ~quiet}, {7'h0, data_oe_out});
    chk("pause sending", 8'h0, {7'h0, sending_out});
  endtask
  task automatic test_power_up();
    chk("released data", 8'h0, {7'h0, data_oe_out});
    chk("released gate", 8'h0, {7'h0, gate_oe_out});
    wait_hi(0, T_DATA_MS * MS + 100, n);
    chk("data delay", 8'h1, {7'h0, n >= T_DATA_MS * MS - 2 && n <= T_DATA_MS * MS + 2});
    wait_hi(1, T_GATE_MS * MS + 100, n);
    chk("gate delay", 8'h1, {7'h0, n >= T_GATE_MS * MS - 2 && n <= T_GATE_MS * MS + 2});
    wait_hi(2, (T_SETTLE_MS + T_PAUSE_MS) * MS + 100, n);
    chk("send delay", 8'h1,
      {7'h0, n >= (T_SETTLE_MS + T_PAUSE_MS) * MS - 2 && n <= (T_SETTLE_MS + T_PAUSE_MS) * MS + 2});
    $display("power-up test done");
  endtask
  task automatic test_passes();
    @(posedge sys_clk_in);
    region_sel_in <= 2'h1;
    chk_pass(8'h41, 1'b0);
    @(posedge sys_clk_in);
    newer_board_in <= 1'b1;
    wait_hi(2, T_PAUSE_MS * MS + 100, n);
    chk("pause length", 8'h1, {7'h0, n >= T_PAUSE_MS * MS - 14 && n <= T_PAUSE_MS * MS - 6});
    chk_pass(8'h45, 1'b0);
    $display("signature pass test done");
  endtask
  // second reset in mid-run: stealth, multi-region, gate left released
  task automatic test_modes();
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    multi_region_in <= 1'b1;
    stealth_in <= 1'b1;
    gate_hold_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("reset data", 8'h0, {7'h0, data_oe_out});
    chk("reset sending", 8'h0, {7'h0, sending_out});
    wait_hi(0, T_DATA_MS * MS + 100, n);
    chk("data delay 2", 8'h1, {7'h0, n >= T_DATA_MS * MS - 2 && n <= T_DATA_MS * MS + 2});
    n = (T_GATE_MS + T_SETTLE_MS + T_PAUSE_MS) * MS;
    wait_hi(2, n + 100, cyc_w);
    chk("send delay 2", 8'h1, {7'h0, cyc_w >= n - 2 && cyc_w <= n + 2});
    chk("gate released", 8'h0, {7'h0, gate_oe_out});
    chk_pass(8'h41, 1'b1);
    repeat (2 * T_PAUSE_MS * MS) @(negedge sys_clk_in);
    chk("stealth quiet", 8'h0, {7'h0, sending_out});
    chk("stealth line", 8'h0, {7'h0, data_oe_out});
    @(posedge sys_clk_in);
    lid_open_sense_in <= 1'b1;
    @(posedge sys_clk_in);
    lid_open_sense_in <= 1'b0;
    wait_hi(2, T_PAUSE_MS * MS + 100, n);
    chk("lid pause", 8'h1, {7'h0, n >= (T_PAUSE_MS - 1) * MS && n <= T_PAUSE_MS * MS + 5});
    chk_pass(8'h45, 1'b1);
    $display("stealth and multi-region test done");
  endtask
  int cyc_w;
  initial begin
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge sys_clk_in);
    test_power_up();
    test_passes();
    test_modes();
    results();
  end
endmodule
